// ===== dpsv_regs.svh
`ifndef DPSV_REGS_SVH
`define DPSV_REGS_SVH

// ************************************************************
// register offsets (byte addresses on apb)
// ************************************************************
`define DPSV_AW 8
`define DPSV_OFF_CTRL 8'h00
`define DPSV_OFF_START 8'h04
`define DPSV_OFF_END 8'h08
`define DPSV_OFF_AMEN 8'h0c
`define DPSV_OFF_WPROT 8'h10
`define DPSV_OFF_STAT 8'h14
`define DPSV_OFF_ICLR 8'h18
`define DPSV_OFF_IEN 8'h1c
`define DPSV_OFF_STATE 8'h20

// ************************************************************
// fields and reset values
// ************************************************************
`define DPSV_CTRL_EN 0
`define DPSV_PAGE_LSB 12
`define DPSV_NPAGE 20
`define DPSV_NCLS 8
`define DPSV_NEV 3
`define DPSV_EV_VTMO 0
`define DPSV_EV_CTMO 1
`define DPSV_EV_WPV 2
`define DPSV_RST_CTRL 1'h0
`define DPSV_RST_START 20'h00000
`define DPSV_RST_END 20'h000ff
`define DPSV_RST_AMEN 8'hff
`define DPSV_RST_WPROT 8'h00
`define DPSV_RST_EV 3'h0

// ************************************************************
// shared ram geometry, address modifiers, slots, timing
// ************************************************************
`define DPSV_RAM_AW 20
`define DPSV_WAW 18
`define DPSV_CPU_BASE_HI 12'h000
`define DPSV_AM_A32 3'h1
`define DPSV_AM_A24 3'h7
`define DPSV_SLOT_VME 2'h2
`define DPSV_CLK_NS 5
`define DPSV_TMO_NS 15000
`define DPSV_TMO_CYC (`DPSV_TMO_NS / `DPSV_CLK_NS)
`define DPSV_TMO_W 12

`endif

// ===== dpsv_pkg.sv
package dpsv_pkg;
`include "dpsv_regs.svh"

    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } dpsv_cpu_req_s;

    typedef struct packed {
        logic as;
        logic ds;
        logic write;
        logic [31:0] addr;
        logic [5:0] am;
        logic [3:0] be;
        logic [31:0] wdata;
    } dpsv_vme_req_s;

    typedef struct packed {
        logic en;
        logic we;
        logic [3:0] be;
        logic [`DPSV_WAW-1:0] addr;
        logic [31:0] wdata;
    } dpsv_ram_cmd_s;

    typedef enum logic [1:0] {
        OWN_NONE,
        OWN_CPU,
        OWN_VME
    } dpsv_owner_e;

    typedef enum logic [2:0] {
        VS_IDLE,
        VS_WAIT,
        VS_RUN,
        VS_ACK,
        VS_ERR
    } dpsv_vstate_e;

endpackage

// ===== dpsv_tmo.sv
`timescale 1ns/1ps
`include "dpsv_regs.svh"
module dpsv_tmo
    import dpsv_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // watch
    input wire logic run,
    output logic expired
);

    logic [`DPSV_TMO_W-1:0] cnt_reg;
    logic hit;

    assign hit = (cnt_reg == `DPSV_TMO_W'(`DPSV_TMO_CYC - 1));

    // restarts whenever the watched access is answered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (!run || hit) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + `DPSV_TMO_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expired <= 1'b0;
        end else begin
            expired <= run && hit; // R10
        end
    end

endmodule

// ===== dpsv_win_dec.sv
`timescale 1ns/1ps
`include "dpsv_regs.svh"
module dpsv_win_dec
    import dpsv_pkg::*;
(
    // slave cycle
    input wire logic [31:0] addr,
    input wire logic [5:0] am,
    // setup
    input wire logic en,
    input wire logic [`DPSV_NPAGE-1:0] start_pg,
    input wire logic [`DPSV_NPAGE-1:0] end_pg,
    input wire logic [`DPSV_NCLS-1:0] am_en,
    input wire logic [`DPSV_NCLS-1:0] wprot,
    // result
    output logic hit,
    output logic wr_ok,
    output logic [`DPSV_RAM_AW-1:0] off
);

    // class = {a24, supervisor, program}; block and a16 codes give none
    function automatic logic [3:0] am_class(input logic [5:0] m);
        logic ok;
        ok = (m[5:3] == `DPSV_AM_A32 || m[5:3] == `DPSV_AM_A24) &&
             (m[1] ^ m[0]);
        return {ok, m[5:3] == `DPSV_AM_A24, m[2], m[1]}; // R08
    endfunction

    logic [3:0] cls;
    logic [`DPSV_NPAGE-1:0] pg;
    logic [`DPSV_NPAGE-1:0] pdiff;

    assign cls = am_class(am);
    // a24 addresses sit zero-extended in the same 4 gbyte map
    assign pg = cls[2] ? {8'h00, addr[23:`DPSV_PAGE_LSB]}
                       : addr[31:`DPSV_PAGE_LSB]; // R03
    assign pdiff = pg - start_pg;
    assign hit = en && cls[3] && am_en[cls[2:0]] &&
                 pg >= start_pg && pg <= end_pg; // R04 R05
    assign wr_ok = !wprot[cls[2:0]]; // R06
    // a window wider than the ram wraps onto it
    assign off = {pdiff[7:0], addr[`DPSV_PAGE_LSB-1:0]}; // R07

endmodule

// ===== dpsv_top.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Contract
// (R01) local processor ram accesses are served at once; vme only fills gaps.
// (R02) processor owns two of three slots, vme the third: 40 plus 20. The ram port does not keep to the slots: cpu_hit wins in every phase.
// (R03) vme window base may lie anywhere in the 32-bit address range.
// (R04) vme cycles are decoded by address and address modifier code.
// (R05) window start and end pages are programmable in 4 kbyte steps.
// (R06) write protection is chosen per address modifier class.
// (R07) the shared ram holds 1 mbyte.
// (R08) slave takes a32 and a24 with d8, d16 and d32 only.
// (R09) unaligned, address-only and read-modify-write cycles are handled.
// (R10) accesses unanswered for 15 us are ended with a bus error.
// (R11) on collision the processor goes first; vme waits for a free slot.
// (R12) a write-protected vme write leaves memory untouched.
`include "dpsv_regs.svh"
module dpsv_top
    import dpsv_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [`DPSV_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // local processor
    input wire dpsv_cpu_req_s cpu_in,
    input wire logic cpu_ext_ack,
    output logic cpu_ack,
    output logic cpu_berr,
    output logic [31:0] cpu_rdata,
    output logic cpu_slot,
    // vmebus slave
    input wire dpsv_vme_req_s vme_in,
    output logic vme_dtack,
    output logic vme_berr,
    output logic [31:0] vme_rdata,
    // shared ram
    output dpsv_ram_cmd_s ram_cmd,
    input wire logic [31:0] ram_rdata,
    // interrupt
    output logic irq
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic ctrl_en_reg;
    logic [`DPSV_NPAGE-1:0] start_reg;
    logic [`DPSV_NPAGE-1:0] end_reg;
    logic [`DPSV_NCLS-1:0] amen_reg;
    logic [`DPSV_NCLS-1:0] wprot_reg;
    logic [`DPSV_NEV-1:0] stat_reg;
    logic [`DPSV_NEV-1:0] stat_next;
    logic [`DPSV_NEV-1:0] ien_reg;
    logic [`DPSV_NEV-1:0] ev;
    logic [`DPSV_NEV-1:0] clr;
    logic [1:0] phase_reg;
    dpsv_owner_e own_reg;
    dpsv_owner_e own_q_reg;
    dpsv_vstate_e vs_reg;
    logic sel_reg;
    logic wok_reg;
    logic [`DPSV_RAM_AW-1:0] off_reg;
    logic loc_pend_reg;
    logic dec_hit;
    logic dec_wok;
    logic [`DPSV_RAM_AW-1:0] dec_off;
    logic cpu_hit;
    logic vme_want;
    logic vme_go;
    logic vme_done;
    logic wp_hit;
    logic vtmo_run;
    logic vtmo;
    logic ctmo;
    logic apb_acc;
    logic apb_wr;
    logic [31:0] rd_val;
    logic rd_ok;

    // ************************************************************
    // apb register file
    // ************************************************************
    // one wait state: pready rises in the second access cycle
    assign apb_acc = psel && penable;
    assign apb_wr = apb_acc && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_acc && !pready;
        end
    end

    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        case (paddr)
            `DPSV_OFF_CTRL: begin
                rd_val[`DPSV_CTRL_EN] = ctrl_en_reg;
            end
            `DPSV_OFF_START: begin
                rd_val[31:`DPSV_PAGE_LSB] = start_reg; // R05
            end
            `DPSV_OFF_END: begin
                rd_val[31:`DPSV_PAGE_LSB] = end_reg;
            end
            `DPSV_OFF_AMEN: begin
                rd_val[`DPSV_NCLS-1:0] = amen_reg;
            end
            `DPSV_OFF_WPROT: begin
                rd_val[`DPSV_NCLS-1:0] = wprot_reg;
            end
            `DPSV_OFF_STAT: begin
                rd_val[`DPSV_NEV-1:0] = stat_reg;
            end
            `DPSV_OFF_ICLR: begin
                rd_val = '0;
            end
            `DPSV_OFF_IEN: begin
                rd_val[`DPSV_NEV-1:0] = ien_reg;
            end
            `DPSV_OFF_STATE: begin
                rd_val[2:0] = vs_reg;
                rd_val[5:4] = phase_reg;
                rd_val[8] = loc_pend_reg;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (apb_acc && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= !rd_ok;
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg <= `DPSV_RST_CTRL;
            start_reg <= `DPSV_RST_START;
            end_reg <= `DPSV_RST_END;
            amen_reg <= `DPSV_RST_AMEN;
            wprot_reg <= `DPSV_RST_WPROT;
            ien_reg <= `DPSV_RST_EV;
        end else if (apb_wr) begin
            case (paddr)
                `DPSV_OFF_CTRL: begin
                    ctrl_en_reg <= pwdata[`DPSV_CTRL_EN];
                end
                `DPSV_OFF_START: begin
                    start_reg <= pwdata[31:`DPSV_PAGE_LSB]; // R03
                end
                `DPSV_OFF_END: begin
                    end_reg <= pwdata[31:`DPSV_PAGE_LSB];
                end
                `DPSV_OFF_AMEN: begin
                    amen_reg <= pwdata[`DPSV_NCLS-1:0]; // R04
                end
                `DPSV_OFF_WPROT: begin
                    wprot_reg <= pwdata[`DPSV_NCLS-1:0]; // R06
                end
                `DPSV_OFF_IEN: begin
                    ien_reg <= pwdata[`DPSV_NEV-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // event status and interrupt
    // ************************************************************
    assign clr = (apb_wr && paddr == `DPSV_OFF_ICLR) ?
                 pwdata[`DPSV_NEV-1:0] : '0;
    assign ev = {wp_hit, ctmo, vtmo};
    // a new event beats a clear in the same cycle
    assign stat_next = (stat_reg & ~clr) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= `DPSV_RST_EV;
            irq <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq <= |(stat_next & ien_reg);
        end
    end

    // ************************************************************
    // slot sequencer
    // ************************************************************
    // the processor is told which cycles are its own; the third is
    // meant for vme, but cpu_hit still takes the ram in any phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= '0;
            cpu_slot <= 1'b0;
        end else begin
            phase_reg <= (phase_reg == `DPSV_SLOT_VME) ? 2'h0
                         : phase_reg + 2'h1; // R02
            cpu_slot <= (phase_reg != 2'h1); // R02
        end
    end

    // ************************************************************
    // shared ram port
    // ************************************************************
    assign cpu_hit = cpu_in.req &&
        cpu_in.addr[31:`DPSV_RAM_AW] == `DPSV_CPU_BASE_HI; // R07
    assign vme_want = vs_reg == VS_WAIT && vme_in.as && vme_in.ds &&
                      sel_reg && (wok_reg || !vme_in.write);
    assign vme_go = vme_want && !cpu_hit; // R11
    assign wp_hit = vs_reg == VS_WAIT && vme_in.as && vme_in.ds &&
                    sel_reg && vme_in.write && !wok_reg;
    assign vme_done = own_q_reg == OWN_VME;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_cmd <= '0;
            own_reg <= OWN_NONE;
        end else if (cpu_hit) begin
            ram_cmd.en <= 1'b1; // R01
            ram_cmd.we <= cpu_in.write;
            ram_cmd.be <= cpu_in.be;
            ram_cmd.addr <= cpu_in.addr[`DPSV_RAM_AW-1:2];
            ram_cmd.wdata <= cpu_in.wdata;
            own_reg <= OWN_CPU;
        end else if (vme_go) begin
            ram_cmd.en <= 1'b1;
            ram_cmd.we <= vme_in.write; // R12
            ram_cmd.be <= vme_in.be; // R09
            ram_cmd.addr <= off_reg[`DPSV_RAM_AW-1:2];
            ram_cmd.wdata <= vme_in.wdata;
            own_reg <= OWN_VME;
        end else begin
            ram_cmd.en <= 1'b0;
            ram_cmd.we <= 1'b0;
            own_reg <= OWN_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_q_reg <= OWN_NONE;
        end else begin
            own_q_reg <= own_reg;
        end
    end

    // ************************************************************
    // local processor answer
    // ************************************************************
    // fixed pipeline latency, never stretched by vme traffic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_rdata <= '0;
        end else begin
            cpu_ack <= own_q_reg == OWN_CPU; // R01
            if (own_q_reg == OWN_CPU) begin
                cpu_rdata <= ram_rdata;
            end
        end
    end

    // accesses outside the ram wait for other local logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc_pend_reg <= 1'b0;
        end else if (cpu_ext_ack || ctmo) begin
            loc_pend_reg <= 1'b0;
        end else if (cpu_in.req && !cpu_hit) begin
            loc_pend_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_berr <= 1'b0;
        end else begin
            cpu_berr <= ctmo; // R10
        end
    end

    dpsv_tmo u_ctmo (
        .pclk(pclk),
        .presetn(presetn),
        .run(loc_pend_reg && !cpu_ext_ack),
        .expired(ctmo)
    );

    // ************************************************************
    // vme slave window
    // ************************************************************
    dpsv_win_dec u_dec (
        .addr(vme_in.addr),
        .am(vme_in.am),
        .en(ctrl_en_reg),
        .start_pg(start_reg),
        .end_pg(end_reg),
        .am_en(amen_reg),
        .wprot(wprot_reg),
        .hit(dec_hit),
        .wr_ok(dec_wok),
        .off(dec_off)
    );

    assign vtmo_run = (vs_reg == VS_WAIT && vme_in.ds && sel_reg) ||
                      vs_reg == VS_RUN;

    dpsv_tmo u_vtmo (
        .pclk(pclk),
        .presetn(presetn),
        .run(vtmo_run),
        .expired(vtmo)
    );

    // decode is latched once per address strobe, so the read and the
    // write of a read-modify-write share one address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= 1'b0;
            wok_reg <= 1'b0;
            off_reg <= '0;
        end else if (vs_reg == VS_IDLE && vme_in.as) begin
            sel_reg <= dec_hit; // R04
            wok_reg <= dec_wok; // R06
            off_reg <= dec_off;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vs_reg <= VS_IDLE;
        end else begin
            case (vs_reg)
                VS_IDLE: begin
                    if (vme_in.as) begin
                        vs_reg <= VS_WAIT;
                    end
                end
                VS_WAIT: begin
                    // strobe without data strobe: address-only, no answer
                    if (!vme_in.as) begin
                        vs_reg <= VS_IDLE; // R09
                    end else if (vtmo || wp_hit) begin
                        vs_reg <= VS_ERR; // R12
                    end else if (vme_go) begin
                        vs_reg <= VS_RUN;
                    end
                end
                VS_RUN: begin
                    if (vme_done) begin
                        vs_reg <= VS_ACK;
                    end else if (vtmo) begin
                        vs_reg <= VS_ERR; // R10
                    end
                end
                VS_ACK, VS_ERR: begin
                    // held until the master drops its data strobe
                    if (!vme_in.ds) begin
                        vs_reg <= vme_in.as ? VS_WAIT : VS_IDLE; // R09
                    end
                end
                default: begin
                    vs_reg <= VS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vme_dtack <= 1'b0;
            vme_berr <= 1'b0;
            vme_rdata <= '0;
        end else begin
            if (vs_reg == VS_RUN && vme_done) begin
                vme_dtack <= 1'b1;
                vme_rdata <= ram_rdata;
            end else if (!vme_in.ds) begin
                vme_dtack <= 1'b0;
            end
            if (vs_reg == VS_WAIT && (vtmo || wp_hit)) begin
                vme_berr <= 1'b1; // R12
            end else if (vs_reg == VS_RUN && !vme_done && vtmo) begin
                vme_berr <= 1'b1; // R10
            end else if (!vme_in.ds) begin
                vme_berr <= 1'b0;
            end
        end
    end

endmodule

// ===== dpsv_properties.sv
`timescale 1ns/1ps
`include "dpsv_regs.svh"
module dpsv_properties
    import dpsv_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // local processor
    input wire dpsv_cpu_req_s cpu_in,
    input wire logic cpu_ext_ack,
    input wire logic cpu_ack,
    input wire logic cpu_berr,
    input wire logic cpu_slot,
    // vmebus and ram
    input wire dpsv_vme_req_s vme_in,
    input wire logic vme_dtack,
    input wire logic vme_berr,
    input wire dpsv_ram_cmd_s ram_cmd
);
localparam int TMO = `DPSV_TMO_CYC;
logic pend_reg;
logic [12:0] cnt_reg;
wire cpu_hit = cpu_in.req && cpu_in.addr[31:20] == 12'h000;

default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);

// ************************************************************
// local access wait counter
// ************************************************************
// a few cycles of slack: both counts start on the same edge, but cpu_berr is seen with the count one above the limit
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
        pend_reg <= 1'b0;
    else if (cpu_ext_ack || cpu_berr)
        pend_reg <= 1'b0;
    else if (cpu_in.req && !cpu_hit)
        pend_reg <= 1'b1;
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
        cnt_reg <= 13'h0000;
    else
        cnt_reg <= pend_reg ? cnt_reg + 13'h0001 : 13'h0000;
end

// ************************************************************
// properties
// ************************************************************
property p_apb_ready;
    psel && penable && !pready |=> pready;
endproperty
a_apb_ready: assert property (p_apb_ready) else $error("apb ready late");

property p_slverr;
    pslverr |-> pready && psel && penable;
endproperty
a_slverr: assert property (p_slverr) else $error("stray slave error");

property p_cpu_cmd;
    cpu_hit |=> ram_cmd.en && ram_cmd.we == $past(cpu_in.write)
        && ram_cmd.addr == $past(cpu_in.addr[19:2]);
endproperty
a_cpu_cmd: assert property (p_cpu_cmd) else $error("cpu not served");

property p_cpu_ack;
    cpu_hit |-> ##3 cpu_ack;
endproperty
a_cpu_ack: assert property (p_cpu_ack) else $error("cpu ack late");

property p_slot;
    cpu_slot ##1 !cpu_slot |=> cpu_slot ##1 cpu_slot ##1 !cpu_slot;
endproperty
a_slot: assert property (p_slot) else $error("slot pattern broken");

property p_ans_hold;
    (vme_dtack || vme_berr) && vme_in.ds |=> $stable({vme_dtack, vme_berr});
endproperty
a_ans_hold: assert property (p_ans_hold) else $error("answer dropped");

property p_release;
    !vme_in.ds |=> !vme_dtack && !vme_berr;
endproperty
a_release: assert property (p_release) else $error("answer kept");

property p_tmo_max;
    pend_reg |-> cnt_reg <= TMO + 8;
endproperty
a_tmo_max: assert property (p_tmo_max) else $error("no bus error");

property p_tmo_min;
    cpu_berr |-> cnt_reg >= TMO - 8;
endproperty
a_tmo_min: assert property (p_tmo_min) else $error("bus error early");

c_cpu: cover property (cpu_hit ##3 cpu_ack);
c_dtack: cover property (vme_dtack);
c_vberr: cover property (vme_berr);
c_cberr: cover property (cpu_berr);
endmodule

bind dpsv_top dpsv_properties i_props (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .pslverr(pslverr),
    .cpu_in(cpu_in),
    .cpu_ext_ack(cpu_ext_ack),
    .cpu_ack(cpu_ack),
    .cpu_berr(cpu_berr),
    .cpu_slot(cpu_slot),
    .vme_in(vme_in),
    .vme_dtack(vme_dtack),
    .vme_berr(vme_berr),
    .ram_cmd(ram_cmd)
);

// ===== dpsv_sram_model.sv
`timescale 1ns/1ps
module dpsv_sram_model
    import dpsv_pkg::*;
(
    // clock
    input wire logic pclk,
    // ram port
    input wire dpsv_ram_cmd_s ram_cmd,
    output logic [31:0] ram_rdata
);
// sparse store: only touched words exist, others read as zero
logic [31:0] mem [int];
logic [31:0] word;

initial ram_rdata = 32'h0;

always @(posedge pclk) begin
    if (ram_cmd.en) begin
        word = mem.exists(int'(ram_cmd.addr)) ? mem[int'(ram_cmd.addr)] : 32'h0;
        for (int i = 0; i < 4; i++) begin
            if (ram_cmd.we && ram_cmd.be[i])
                word[8*i+:8] = ram_cmd.wdata[8*i+:8];
        end
        if (ram_cmd.we)
            mem[int'(ram_cmd.addr)] = word;
        ram_rdata <= word;
    end else begin
        // data is not held past its cycle
        ram_rdata <= ~ram_rdata;
    end
end
endmodule

// ===== dual_port_sram_vme_slave_window_tb_top.sv
`timescale 1ns/1ps
module dual_port_sram_vme_slave_window_tb_top
    import dpsv_pkg::*;
();
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_ext_ack = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, cpu_rdata, vme_rdata, ram_rdata, r;
logic pready, pslverr, cpu_ack, cpu_berr, cpu_slot, vme_dtack, vme_berr;
logic irq, e, k;
dpsv_cpu_req_s cpu_in = '0;
dpsv_vme_req_s vme_in = '0;
dpsv_ram_cmd_s ram_cmd;
int miscompares = 0, comparisons = 0;
logic [7:0] rst_a [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
logic [31:0] rst_v [5] = '{32'h0, 32'h0, 32'h000ff000, 32'hff, 32'h0};

dpsv_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_in(cpu_in),
    .cpu_ext_ack(cpu_ext_ack), .cpu_ack(cpu_ack), .cpu_berr(cpu_berr),
    .cpu_rdata(cpu_rdata), .cpu_slot(cpu_slot), .vme_in(vme_in),
    .vme_dtack(vme_dtack), .vme_berr(vme_berr), .vme_rdata(vme_rdata),
    .ram_cmd(ram_cmd), .ram_rdata(ram_rdata), .irq(irq));
dpsv_sram_model i_ram (.pclk(pclk), .ram_cmd(ram_cmd), .ram_rdata(ram_rdata));

initial forever #2.5 pclk = ~pclk;

// ************************************************************
// tasks
// ************************************************************
task tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask

task chk32(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
        miscompares++;
        $display("BAD %0t word %h expected %h", $time, g, x);
    end
endtask

task chk1(input logic g, input logic x);
    comparisons++;
    if (g !== x) begin
        miscompares++;
        $display("BAD %0t flag %b expected %b", $time, g, x);
    end
endtask

task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
endtask

task cpu(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    cpu_in <= '{1'b1, w, a, 4'hf, d};
    @(posedge pclk);
    cpu_in.req <= 1'b0;
    do @(posedge pclk);
    while (cpu_ack !== 1'b1 && cpu_berr !== 1'b1);
    r = cpu_rdata;
    e = cpu_berr;
    cpu_in.wdata <= ~d;
endtask

// lim short where no answer is expected: silence is the result
task vme(input logic w, input logic [31:0] a, input logic [5:0] m,
         input logic [3:0] b, input logic [31:0] d, input int lim);
    int n;
    n = 0;
    @(posedge pclk);
    vme_in <= '{1'b1, 1'b0, w, a, m, b, d};
    @(posedge pclk);
    vme_in.ds <= 1'b1;
    do @(posedge pclk);
    while (vme_dtack !== 1'b1 && vme_berr !== 1'b1 && n++ < lim);
    r = vme_rdata;
    e = vme_berr;
    k = vme_dtack;
    vme_in.ds <= 1'b0;
    @(posedge pclk);
    vme_in <= '{1'b0, 1'b0, ~w, ~a, ~m, ~b, ~d};
endtask

// ************************************************************
// tests
// ************************************************************
initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_a[i]) begin
        apb(1'b0, rst_a[i], 32'h0);
        chk32(r, rst_v[i]);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    vme(1'b0, 32'h00000100, 6'h0d, 4'hf, 32'h0, 40);
    chk1(k | e, 1'b0);
    apb(1'b1, 8'h04, 32'h80000000);
    apb(1'b1, 8'h08, 32'h800ff000);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk32(r, 32'h80000000);
    cpu(1'b1, 32'h100, 32'h11223344);
    vme(1'b0, 32'h80000100, 6'h0d, 4'hf, 32'h0, 400);
    chk1(k, 1'b1);
    chk32(r, 32'h11223344);
    vme(1'b1, 32'h80000100, 6'h0d, 4'h3, 32'haaaabbbb, 400);
    chk1(k, 1'b1);
    cpu(1'b0, 32'h100, 32'h0);
    chk32(r, 32'h1122bbbb);
    vme(1'b1, 32'h80000100, 6'h09, 4'hf, 32'hdeadbeef, 400);
    chk1(e, 1'b1);
    cpu(1'b0, 32'h100, 32'h0);
    chk32(r, 32'h1122bbbb);
    vme(1'b0, 32'h80000100, 6'h09, 4'hf, 32'h0, 400);
    chk1(k, 1'b1);
    chk32(r, 32'h1122bbbb);
    apb(1'b0, 8'h14, 32'h0);
    chk32(r, 32'h4);
    chk1(irq, 1'b0);
    apb(1'b1, 8'h1c, 32'h4);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b1);
    apb(1'b1, 8'h18, 32'h4);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    vme(1'b1, 32'h800ffffc, 6'h0d, 4'hf, 32'h5a5aa5a5, 400);
    chk1(k, 1'b1);
    cpu(1'b0, 32'h000ffffc, 32'h0);
    chk32(r, 32'h5a5aa5a5);
    vme(1'b0, 32'h80100000, 6'h0d, 4'hf, 32'h0, 40);
    chk1(k | e, 1'b0);
    vme(1'b0, 32'h00000100, 6'h3d, 4'hf, 32'h0, 40);
    chk1(k | e, 1'b0);
    cpu(1'b0, 32'h40000000, 32'h0);
    chk1(e, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk32(r, 32'h2);
    tally_and_finish;
end

initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    tally_and_finish;
end
endmodule
